/* File: core/cocw_pkg.sv */
// Package: field layout, defaults and mode codes of the output configuration word
package cocw_pkg;
   localparam int WORD_W = 32;
   localparam int SEL_LOW_BIT = 0;
   localparam int SEL_HIGH_BIT = 1;
   localparam logic [1:0] SEL_THIS_WORD = 2'h1;
   localparam int PAIRS = 5;
   localparam int STD_LSB = 2;
   localparam int MODE_LSB = 7;
   localparam int MODE_W = 2;
   localparam int REF_STATUS_BIT = 27;
   localparam int SHARED_PIN_BIT = 28;
   localparam int LOCK_TYPE_BIT = 29;
   localparam int SHIFT_DIV4_BIT = 30;
   localparam int SHIFT_DIV8_BIT = 31;
   localparam logic [4:0] STD_RESET = 5'h1F;
   localparam logic [19:0] MODE_RESET = 20'h00000;
   localparam logic REF_STATUS_RESET = 1'b0;
   localparam logic SHARED_PIN_RESET = 1'b0;
   localparam logic LOCK_TYPE_RESET = 1'b0;
   localparam logic SHIFT_DIV4_RESET = 1'b0;
   localparam logic SHIFT_DIV8_RESET = 1'b0;
   // Encoded quarter-shift state handed to the output dividers
   localparam logic [1:0] SHIFT_NONE = 2'h0;
   localparam logic [1:0] SHIFT_DIV4 = 2'h1;
   localparam logic [1:0] SHIFT_DIV8 = 2'h2;
endpackage

/* File: core/cocw_shift_decode.sv */
// Phase-shift enable decode shared by all output pairs
`timescale 1ns/1ps
module cocw_shift_decode (
   input wire logic div4_en,
   input wire logic div8_en,
   output logic [1:0] shift_mode,
   output logic div16_allowed
);
   always_comb begin
      // Both set is treated as off
      if (div4_en && !div8_en) begin
         shift_mode = cocw_pkg::SHIFT_DIV4;
      end else if (div8_en && !div4_en) begin
         shift_mode = cocw_pkg::SHIFT_DIV8;
      end else begin
         shift_mode = cocw_pkg::SHIFT_NONE;
      end
      // Either enable bit alone withdraws divide-by-16, even in the both-set case
      div16_allowed = !(div4_en || div8_en);
   end
endmodule // cocw_shift_decode

/* File: core/cocw_config_word.sv */
// Output format and status configuration word register
//
// Notes on behaviour
// - Write-only word link, no read-back
// - Defaults on reset and power-down control
// - Bits 2-6: pair standard, 1 differential
// - Bits 7-26: ten two-bit modes, default zero
// - Bit 27 steers reference-status pin source
// - Bit 28 picks shared pin function
// - Bit 29 picks digital or analog lock
// - Bit 30 enables div-4 quarter shift
// - Bit 31 enables div-8 quarter shift
// - Shift enabled removes divide-by-16 mode
// - Shifted outputs switch in pairs
// - Both shift bits set means none
`timescale 1ns/1ps
module cocw_config_word (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic power_down_control_b,
   input wire logic word_valid,
   input wire logic [31:0] word_data,
   input wire logic ref_clock_status,
   input wire logic primary_reference_selected,
   input wire logic oscillator_status_in,
   output logic [4:0] pair_signal_standard,
   output logic [19:0] output_mode,
   output logic ref_status_pin_select,
   output logic shared_pin_function_select,
   output logic lock_indicator_type,
   output logic quarter_shift_div4_enable,
   output logic quarter_shift_div8_enable,
   output logic ref_status_out,
   output logic oscillator_status_output,
   output logic pump_reference_resistor_en,
   output logic [1:0] shift_mode,
   output logic div16_allowed,
   output logic [4:0] pair_switch_ganged
);
   // Per-pair fields gathered back into the flat port order
   wire [4:0] std_w;
   wire [19:0] mode_w;

   // Single-bit fields, one register group each
   logic ref_status_pin_select_q;
   logic ref_status_pin_select_d;
   logic shared_q;
   logic shared_d;
   logic lock_q;
   logic lock_d;
   logic div4_q;
   logic div4_d;
   logic div8_q;
   logic div8_d;

   // Registered status pins
   logic ref_status_q;
   logic ref_status_d;
   logic osc_q;
   logic osc_d;

   // Decoded phase-shift state
   logic [1:0] shift_mode_w;
   logic div16_allowed_w;

   // Word qualification
   logic sel_low;
   logic sel_high;
   logic load;
   logic defaults;

   // The select bits only steer the load; they are never stored
   assign sel_low = word_data[cocw_pkg::SEL_LOW_BIT];
   assign sel_high = word_data[cocw_pkg::SEL_HIGH_BIT];

   // Word-only writes; nothing is driven back to the host
   assign load = word_valid && ({sel_high, sel_low} == cocw_pkg::SEL_THIS_WORD);

   // Power-down forces defaults, taking priority over a word in flight
   assign defaults = !power_down_control_b;

   // One register group per output pair: signal standard plus the A and B modes
   for (genvar p = 0; p < cocw_pkg::PAIRS; p++) begin : g_pair
      logic std_q;
      logic std_d;
      logic [1:0] mode_a_q;
      logic [1:0] mode_a_d;
      logic [1:0] mode_b_q;
      logic [1:0] mode_b_d;

      always_comb begin
         std_d = std_q;
         mode_a_d = mode_a_q;
         mode_b_d = mode_b_q;
         if (defaults) begin
            std_d = cocw_pkg::STD_RESET[p];
            mode_a_d = cocw_pkg::MODE_RESET[2 * cocw_pkg::MODE_W * p +: cocw_pkg::MODE_W];
            mode_b_d = cocw_pkg::MODE_RESET[(2 * p + 1) * cocw_pkg::MODE_W +: cocw_pkg::MODE_W];
         end else if (load) begin
            std_d = word_data[cocw_pkg::STD_LSB + p];
            // A mode sits below B mode, each low bit first
            mode_a_d = word_data[cocw_pkg::MODE_LSB + 2 * cocw_pkg::MODE_W * p +: cocw_pkg::MODE_W];
            mode_b_d = word_data[cocw_pkg::MODE_LSB + (2 * p + 1) * cocw_pkg::MODE_W +:
               cocw_pkg::MODE_W];
         end
      end

      always_ff @(posedge clock) begin
         if (!rst_b) begin
            std_q <= cocw_pkg::STD_RESET[p];
            mode_a_q <= cocw_pkg::MODE_RESET[2 * cocw_pkg::MODE_W * p +: cocw_pkg::MODE_W];
            mode_b_q <= cocw_pkg::MODE_RESET[(2 * p + 1) * cocw_pkg::MODE_W +: cocw_pkg::MODE_W];
         end else begin
            std_q <= std_d;
            mode_a_q <= mode_a_d;
            mode_b_q <= mode_b_d;
         end
      end

      assign std_w[p] = std_q;
      assign mode_w[2 * cocw_pkg::MODE_W * p +: cocw_pkg::MODE_W] = mode_a_q;
      assign mode_w[(2 * p + 1) * cocw_pkg::MODE_W +: cocw_pkg::MODE_W] = mode_b_q;

      // With a shift active, both outputs of the pair switch as one unit
      assign pair_switch_ganged[p] = (shift_mode_w != cocw_pkg::SHIFT_NONE);
   end

   // Reference-status source select
   always_comb begin
      ref_status_pin_select_d = ref_status_pin_select_q;
      if (defaults) begin
         ref_status_pin_select_d = cocw_pkg::REF_STATUS_RESET;
      end else if (load) begin
         ref_status_pin_select_d = word_data[cocw_pkg::REF_STATUS_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ref_status_pin_select_q <= cocw_pkg::REF_STATUS_RESET;
      end else begin
         ref_status_pin_select_q <= ref_status_pin_select_d;
      end
   end

   // Shared pin function select
   always_comb begin
      shared_d = shared_q;
      if (defaults) begin
         shared_d = cocw_pkg::SHARED_PIN_RESET;
      end else if (load) begin
         shared_d = word_data[cocw_pkg::SHARED_PIN_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         shared_q <= cocw_pkg::SHARED_PIN_RESET;
      end else begin
         shared_q <= shared_d;
      end
   end

   // Lock indication type
   always_comb begin
      lock_d = lock_q;
      if (defaults) begin
         lock_d = cocw_pkg::LOCK_TYPE_RESET;
      end else if (load) begin
         lock_d = word_data[cocw_pkg::LOCK_TYPE_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         lock_q <= cocw_pkg::LOCK_TYPE_RESET;
      end else begin
         lock_q <= lock_d;
      end
   end

   // Quarter shift enable for the divide-by-4 mode
   always_comb begin
      div4_d = div4_q;
      if (defaults) begin
         div4_d = cocw_pkg::SHIFT_DIV4_RESET;
      end else if (load) begin
         div4_d = word_data[cocw_pkg::SHIFT_DIV4_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         div4_q <= cocw_pkg::SHIFT_DIV4_RESET;
      end else begin
         div4_q <= div4_d;
      end
   end

   // Quarter shift enable for the divide-by-8 mode
   always_comb begin
      div8_d = div8_q;
      if (defaults) begin
         div8_d = cocw_pkg::SHIFT_DIV8_RESET;
      end else if (load) begin
         div8_d = word_data[cocw_pkg::SHIFT_DIV8_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         div8_q <= cocw_pkg::SHIFT_DIV8_RESET;
      end else begin
         div8_q <= div8_d;
      end
   end

   // Status pin sources; registered so the pins never glitch on a select change
   always_comb begin
      ref_status_d = ref_status_pin_select_q ? primary_reference_selected : ref_clock_status;
      osc_d = shared_q ? 1'b0 : oscillator_status_in;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ref_status_q <= 1'b0;
         osc_q <= 1'b0;
      end else begin
         ref_status_q <= ref_status_d;
         osc_q <= osc_d;
      end
   end

   cocw_shift_decode u_shift (
      .div4_en(div4_q),
      .div8_en(div8_q),
      .shift_mode(shift_mode_w),
      .div16_allowed(div16_allowed_w)
   );

   // Field outputs come straight from their flip-flops
   assign pair_signal_standard = std_w;
   assign output_mode = mode_w;
   assign ref_status_pin_select = ref_status_pin_select_q;
   assign shared_pin_function_select = shared_q;
   assign lock_indicator_type = lock_q;
   assign quarter_shift_div4_enable = div4_q;
   assign quarter_shift_div8_enable = div8_q;
   assign ref_status_out = ref_status_q;
   assign oscillator_status_output = osc_q;
   assign pump_reference_resistor_en = shared_q;
   assign shift_mode = shift_mode_w;
   assign div16_allowed = div16_allowed_w;
   // The feedback divider at sixteen is the host's job; not checked here
endmodule // cocw_config_word

/* File: sim/cocw_config_word_props.sv */
// Checker on the configuration word ports
`timescale 1ns/1ps
module cocw_config_word_props (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic power_down_control_b,
   input wire logic word_valid,
   input wire logic [31:0] word_data,
   input wire logic ref_clock_status,
   input wire logic primary_reference_selected,
   input wire logic oscillator_status_in,
   input wire logic [4:0] pair_signal_standard,
   input wire logic [4:0] pair_switch_ganged,
   input wire logic [19:0] output_mode,
   input wire logic ref_status_pin_select,
   input wire logic shared_pin_function_select,
   input wire logic lock_indicator_type,
   input wire logic quarter_shift_div4_enable,
   input wire logic quarter_shift_div8_enable,
   input wire logic ref_status_out,
   input wire logic oscillator_status_output,
   input wire logic pump_reference_resistor_en,
   input wire logic div16_allowed,
   input wire logic [1:0] shift_mode
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire ld = word_valid && power_down_control_b && word_data[1:0] == 2'h1;
   wire d4 = quarter_shift_div4_enable;
   wire d8 = quarter_shift_div8_enable;
   wire [29:0] f = {d8, d4, lock_indicator_type, shared_pin_function_select,
      ref_status_pin_select, output_mode, pair_signal_standard};
   a_load_word: assert property (ld |=> f == $past(word_data[31:2]))
      else $error("word not loaded");
   a_hold_refused: assert property (!ld && power_down_control_b |=> $stable(f))
      else $error("field changed");
   a_pd_default: assert property (!power_down_control_b |=> f == 30'h0000001F)
      else $error("no defaults");
   a_ref_mux: assert property (1'b1 |=> ref_status_out ==
      $past(ref_status_pin_select ? primary_reference_selected : ref_clock_status)) else $error("ref");
   a_osc_mux: assert property (1'b1 |=> oscillator_status_output ==
      $past(!shared_pin_function_select && oscillator_status_in)) else $error("osc");
   a_pump_pin: assert property (pump_reference_resistor_en == shared_pin_function_select)
      else $error("pump");
   a_shift_code: assert property (shift_mode == {d8 && !d4, d4 && !d8})
      else $error("shift");
   a_div16_gang: assert property (div16_allowed == !(d4 || d8) &&
      pair_switch_ganged == {5{shift_mode != 2'h0}}) else $error("div16 or pairs");
   c_back_to_back: cover property (ld ##1 ld);
   c_both_shift: cover property (d4 && d8);
   c_power_down: cover property (!power_down_control_b);
endmodule // cocw_config_word_props
bind cocw_config_word cocw_config_word_props u_props (.*);

/* File: sim/cocw_host_model.sv */
// Host writing whole configuration words
`timescale 1ns/1ps
module cocw_host_model (
   output logic word_valid,
   output logic [31:0] word_data
);
   initial word_valid = 1'b0;
   initial word_data = 32'h00000000;
   // No answer is awaited; the feedback divider lives in another word
   task automatic send(input logic v, input logic [31:0] w);
      word_valid = v;
      // Idle data shows its inverse so a stale word never looks fresh
      word_data = v ? w : ~word_data;
   endtask
endmodule // cocw_host_model

/* File: sim/cocw_config_word_tb_top.sv */
// Self-checking bench for the configuration word
`timescale 1ns/1ps
module cocw_config_word_tb_top;
   logic clock = 1'b0, rst_b = 1'b0, power_down_control_b = 1'b1, v;
   logic ref_clock_status = 1'b0, primary_reference_selected = 1'b0, oscillator_status_in = 1'b0;
   logic ref_status_pin_select, shared_pin_function_select, lock_indicator_type, ref_status_out;
   logic quarter_shift_div4_enable, quarter_shift_div8_enable, oscillator_status_output;
   logic pump_reference_resistor_en, div16_allowed;
   logic [4:0] pair_signal_standard, pair_switch_ganged;
   logic [19:0] output_mode;
   logic [1:0] shift_mode;
   wire word_valid;
   wire [31:0] word_data;
   logic [31:0] lfsr = 32'h00000021, w;
   logic [29:0] e = 30'h0000001F;
   logic [40:0] g, x;
   logic er = 1'b0, eo = 1'b0;
   logic [1:0] es;
   int errors = 0, samples_checked = 0;
   cocw_config_word DUT (.*);
   cocw_host_model host (.*);
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_sim();
      if (errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check();
      // Both enables set count as no shift, yet divide-by-16 stays withdrawn
      es = (e[28] && !e[29]) ? cocw_pkg::SHIFT_DIV4 :
         (e[29] && !e[28]) ? cocw_pkg::SHIFT_DIV8 : cocw_pkg::SHIFT_NONE;
      x = {e, er, eo, e[26], es, !(e[28] || e[29]), {5{es != cocw_pkg::SHIFT_NONE}}};
      g = {quarter_shift_div8_enable, quarter_shift_div4_enable, lock_indicator_type,
         shared_pin_function_select, ref_status_pin_select, output_mode, pair_signal_standard,
         ref_status_out, oscillator_status_output, pump_reference_resistor_en, shift_mode,
         div16_allowed, pair_switch_ganged};
      samples_checked++;
      if (g !== x) begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, x);
      end
   endtask
   initial forever #2.5 clock = ~clock;
   // About 200 words at 5 ns each; twenty times that margin before giving up
   initial begin
      #20000;
      errors++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge clock);
      #1 rst_b = 1'b1;
      check();
      for (int i = 0; i < 200; i++) begin
         lfsr = lfsr_next(lfsr);
         // Two fixed words first: one shift enable, then both at once
         w = i == 0 ? 32'h40000005 : i == 1 ? 32'hC0000001 : {lfsr[31:2], lfsr[0] ? 2'h1 : lfsr[2:1]};
         v = i < 2 || lfsr[4:3] != 2'h0;
         power_down_control_b = i < 2 || lfsr[7:5] != 3'h0;
         {ref_clock_status, primary_reference_selected, oscillator_status_in} = lfsr[10:8];
         host.send(v, w);
         // Status pins follow the select held before this edge, one cycle late
         er = e[25] ? primary_reference_selected : ref_clock_status;
         eo = !e[26] && oscillator_status_in;
         if (!power_down_control_b) e = 30'h0000001F;
         else if (v && w[1:0] == 2'h1) e = w[31:2];
         @(posedge clock);
         #1 check();
      end
      end_sim();
   end
endmodule // cocw_config_word_tb_top
